/* hw/ivt_defines.vh */
`ifndef IVT_DEFINES_VH
`define IVT_DEFINES_VH
// Node and trap counts
`define IVT_NODES 8
`define IVT_NODE_W 3
`define IVT_TRAPS 4
`define IVT_TRAP_W 2
`define IVT_PRIO_W 4
`define IVT_TRAPNUM_W 7
// Vector spacing field: code 0 selects 4 bytes (two words) per vector
`define IVT_SPC_W 2
`define IVT_SPC_RST 2'h0
// Spacing code 0 already means 4 bytes, so the code is added to this base shift
`define IVT_SPC_SHIFT 3'h2
`define IVT_SEG_W 8
`define IVT_SEG_RST 8'h00
`define IVT_OFS_W 12
// Trap numbers of the hardware trap entries, highest priority first
`define IVT_TRAP0_NUM 7'h02
`define IVT_TRAP1_NUM 7'h04
`define IVT_TRAP2_NUM 7'h06
`define IVT_TRAP3_NUM 7'h0A
// Base trap number of the node array; node i uses base plus i
`define IVT_NODE_BASE 7'h27
`define IVT_TRAP_PRIO 4'hF
`define IVT_ZERO_PRIO 4'h0
`endif

/* hw/ivt_vec_calc.v */
`timescale 1ns/1ps
`include "ivt_defines.vh"
// Registered vector address: segment, then trap number scaled by spacing
module ivt_vec_calc (
   input wire core_clk,
   input wire arst_n,
   input wire load,
   input wire [`IVT_TRAPNUM_W-1:0] trapNum,
   input wire [`IVT_SPC_W-1:0] spacing,
   input wire [`IVT_SEG_W-1:0] segment,
   output reg [`IVT_SEG_W+`IVT_OFS_W-1:0] vecAddr_q
);
   wire [`IVT_OFS_W-1:0] ofsWide;
   // Spacing code n gives 4 << n bytes per vector
   // Shift amount kept three bits wide; a two-bit sum would wrap for the two widest spacings
   assign ofsWide = {{(`IVT_OFS_W-`IVT_TRAPNUM_W){1'b0}}, trapNum} << ({1'b0, spacing} + `IVT_SPC_SHIFT);
   // Output held in a flop so the branch address is stable for the core
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         vecAddr_q <= {(`IVT_SEG_W+`IVT_OFS_W){1'b0}};
      end else if (load) begin
         vecAddr_q <= {segment, ofsWide};
      end
   end
endmodule

/* hw/ivt_trap_entry.v */
`timescale 1ns/1ps
`include "ivt_defines.vh"
module ivt_trap_entry (
   input wire core_clk,
   input wire arst_n,
   input wire [`IVT_NODES-1:0] periphReq,
   input wire [`IVT_NODES-1:0] swSetReq,
   input wire [`IVT_NODES-1:0] swClrReq,
   input wire [`IVT_NODES-1:0] nodeEnable,
   input wire [`IVT_NODES*`IVT_PRIO_W-1:0] nodePrio,
   input wire [`IVT_NODES-1:0] nodeToEvent,
   input wire [`IVT_TRAPS-1:0] trapEvent,
   input wire [`IVT_TRAPS-1:0] trapFlagClr,
   input wire [`IVT_SEG_W-1:0] segWrData,
   input wire segWrEn,
   input wire [`IVT_SPC_W-1:0] spcWrData,
   input wire spcWrEn,
   input wire serviceDone,
   input wire [`IVT_PRIO_W-1:0] cpuPrio,
   output reg [`IVT_NODES-1:0] nodeRequestFlag_q,
   output reg [`IVT_TRAPS-1:0] trapFlagRegister_q,
   output reg [`IVT_SEG_W-1:0] vectorSegmentSelect_q,
   output reg [`IVT_SPC_W-1:0] vectorSpacingField_q,
   output reg branchReq_q,
   output reg branchIsTrap_q,
   output reg [`IVT_TRAPNUM_W-1:0] branchTrapNum_q,
   output reg [`IVT_PRIO_W-1:0] branchPrio_q,
   output reg eventXferReq_q,
   output reg [`IVT_NODE_W-1:0] eventXferNode_q,
   output reg trapActive_q,
   output wire [`IVT_SEG_W+`IVT_OFS_W-1:0] vectorAddr_q
);
   localparam ST_IDLE = 2'b00;
   localparam ST_INTR = 2'b01;
   localparam ST_TRAP = 2'b10;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`IVT_TRAP_W-1:0] activeTrap_q;
   reg [`IVT_TRAPS-1:0] trapPend_q;
   reg [`IVT_NODES-1:0] reqFlag_d;
   reg [`IVT_TRAPS-1:0] trapFlag_d;
   reg [`IVT_TRAPS-1:0] trapPend_d;
   reg [`IVT_TRAPS-1:0] trapKeep_d;
   reg winValid;
   reg [`IVT_NODE_W-1:0] winNode;
   reg [`IVT_PRIO_W-1:0] winPrio;
   reg trapValid;
   reg [`IVT_TRAP_W-1:0] trapSel;
   reg takeTrap;
   reg takeNode;
   reg [`IVT_TRAPNUM_W-1:0] calcNum;
   integer i;
   integer j;

   // Trap number of a hardware trap index
   function [`IVT_TRAPNUM_W-1:0] trapNumOf;
      input [`IVT_TRAP_W-1:0] idx;
      begin
         case (idx)
            2'h0: trapNumOf = `IVT_TRAP0_NUM;
            2'h1: trapNumOf = `IVT_TRAP1_NUM;
            2'h2: trapNumOf = `IVT_TRAP2_NUM;
            default: trapNumOf = `IVT_TRAP3_NUM;
         endcase
      end
   endfunction

   // Trap number of a node index
   function [`IVT_TRAPNUM_W-1:0] nodeNumOf;
      input [`IVT_NODE_W-1:0] idx;
      begin
         nodeNumOf = `IVT_NODE_BASE + {{(`IVT_TRAPNUM_W-`IVT_NODE_W){1'b0}}, idx};
      end
   endfunction

   // Request flags: hardware and software sets win over a clear in the same cycle
   always @* begin
      reqFlag_d = (nodeRequestFlag_q & ~swClrReq) | periphReq | swSetReq;
      if (takeNode) begin
         reqFlag_d[winNode] = periphReq[winNode] | swSetReq[winNode];
      end
   end

   // Node arbitration; ties go to the lower index, so scan downward
   always @* begin
      winValid = 1'b0;
      winNode = {`IVT_NODE_W{1'b0}};
      winPrio = `IVT_ZERO_PRIO;
      for (i = `IVT_NODES - 1; i >= 0; i = i - 1) begin
         if (nodeRequestFlag_q[i] && nodeEnable[i] && (nodePrio[i*`IVT_PRIO_W +: `IVT_PRIO_W] > cpuPrio) &&
             (!winValid || nodePrio[i*`IVT_PRIO_W +: `IVT_PRIO_W] >= winPrio)) begin
            winValid = 1'b1;
            winNode = i[`IVT_NODE_W-1:0];
            winPrio = nodePrio[i*`IVT_PRIO_W +: `IVT_PRIO_W];
         end
      end
   end

   // Pending traps, lowest index has highest priority
   always @* begin
      trapPend_d = trapPend_q | trapEvent;
      trapValid = 1'b0;
      trapSel = {`IVT_TRAP_W{1'b0}};
      for (j = `IVT_TRAPS - 1; j >= 0; j = j - 1) begin
         if (trapPend_d[j]) begin
            trapValid = 1'b1;
            trapSel = j[`IVT_TRAP_W-1:0];
         end
      end
   end

   // Entry decision; a trap pre-empts idle or interrupt service, but only a higher trap pre-empts a trap
   always @* begin
      state_d = state_q;
      takeTrap = 1'b0;
      takeNode = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (trapValid) begin
               takeTrap = 1'b1;
            end else if (winValid) begin
               takeNode = 1'b1;
            end
         end
         ST_INTR: begin
            if (trapValid) begin
               takeTrap = 1'b1;
            end else if (serviceDone) begin
               state_d = ST_IDLE;
            end else if (winValid) begin
               takeNode = 1'b1;
            end
         end
         ST_TRAP: begin
            // Interrupts and event transfers are held off for the whole trap service
            if (trapValid && (trapSel < activeTrap_q)) begin
               takeTrap = 1'b1;
            end else if (serviceDone) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (takeTrap) begin
         state_d = ST_TRAP;
      end else if (takeNode && !nodeToEvent[winNode]) begin
         state_d = ST_INTR;
      end
      trapFlag_d = (trapFlagRegister_q & ~trapFlagClr) | trapEvent;
      // Taken trap leaves the pending set; the others keep waiting
      trapKeep_d = trapPend_d;
      if (takeTrap) begin
         trapKeep_d[trapSel] = 1'b0;
      end
      calcNum = takeTrap ? trapNumOf(trapSel) : nodeNumOf(winNode);
   end

   // Main state and output registers
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         activeTrap_q <= {`IVT_TRAP_W{1'b0}};
         trapPend_q <= {`IVT_TRAPS{1'b0}};
         nodeRequestFlag_q <= {`IVT_NODES{1'b0}};
         trapFlagRegister_q <= {`IVT_TRAPS{1'b0}};
         vectorSegmentSelect_q <= `IVT_SEG_RST;
         vectorSpacingField_q <= `IVT_SPC_RST;
         branchReq_q <= 1'b0;
         branchIsTrap_q <= 1'b0;
         branchTrapNum_q <= {`IVT_TRAPNUM_W{1'b0}};
         branchPrio_q <= `IVT_ZERO_PRIO;
         eventXferReq_q <= 1'b0;
         eventXferNode_q <= {`IVT_NODE_W{1'b0}};
         trapActive_q <= 1'b0;
      end else begin
         state_q <= state_d;
         trapPend_q <= trapKeep_d;
         nodeRequestFlag_q <= reqFlag_d;
         trapFlagRegister_q <= trapFlag_d;
         if (segWrEn) begin
            vectorSegmentSelect_q <= segWrData;
         end
         if (spcWrEn) begin
            vectorSpacingField_q <= spcWrData;
         end
         if (takeTrap) begin
            activeTrap_q <= trapSel;
         end
         // Branch request pulses for one cycle, together with the vector address
         branchReq_q <= takeTrap | (takeNode & ~nodeToEvent[winNode]);
         eventXferReq_q <= ~takeTrap & takeNode & nodeToEvent[winNode];
         if (takeTrap | takeNode) begin
            branchIsTrap_q <= takeTrap;
            branchTrapNum_q <= calcNum;
            branchPrio_q <= takeTrap ? `IVT_TRAP_PRIO : winPrio;
            eventXferNode_q <= winNode;
         end
         trapActive_q <= (state_d == ST_TRAP);
      end
   end

   // Vector address registered in the same cycle as the branch request
   ivt_vec_calc uVec (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .load(takeTrap | takeNode),
      .trapNum(calcNum),
      .spacing(vectorSpacingField_q),
      .segment(vectorSegmentSelect_q),
      .vecAddr_q(vectorAddr_q)
   );
endmodule

/* tb/ivt_trap_entry_monitor.sv */
`timescale 1ns/1ps
`include "ivt_defines.vh"
module ivt_trap_entry_monitor (
   input wire core_clk,
   input wire arst_n,
   input wire [`IVT_NODES-1:0] swSetReq,
   input wire [`IVT_TRAPS-1:0] trapEvent,
   input wire [`IVT_TRAPS-1:0] trapFlagClr,
   input wire [`IVT_PRIO_W-1:0] cpuPrio,
   input wire [`IVT_NODES-1:0] nodeRequestFlag_q,
   input wire [`IVT_TRAPS-1:0] trapFlagRegister_q,
   input wire [`IVT_SEG_W-1:0] vectorSegmentSelect_q,
   input wire [`IVT_SPC_W-1:0] vectorSpacingField_q,
   input wire branchReq_q,
   input wire branchIsTrap_q,
   input wire [`IVT_TRAPNUM_W-1:0] branchTrapNum_q,
   input wire [`IVT_PRIO_W-1:0] branchPrio_q,
   input wire eventXferReq_q,
   input wire trapActive_q,
   input wire [`IVT_SEG_W+`IVT_OFS_W-1:0] vectorAddr_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Trap entry, flags and blocking
   a_trap_branch: assert property (trapEvent[0] |=> branchReq_q && branchIsTrap_q && branchTrapNum_q == 7'h02)
      else $error("top trap not taken");
   a_trap_flag: assert property (trapEvent[1] && !trapFlagClr[1] |=> trapFlagRegister_q[1])
      else $error("trap flag not set");
   a_flag_sticky: assert property (trapFlagRegister_q[0] && !trapFlagClr[0] |=> trapFlagRegister_q[0])
      else $error("trap flag lost");
   a_trap_prio: assert property (branchReq_q && branchIsTrap_q |-> branchPrio_q == 4'hF && trapActive_q)
      else $error("trap branch state wrong");
   a_trap_blocks: assert property (trapActive_q && $past(trapActive_q) |->
      !eventXferReq_q && (branchIsTrap_q || !branchReq_q))
      else $error("node served in trap");
   // Vector address and node acceptance; segment and spacing as they stood at the accept edge
   a_vec_addr: assert property (branchReq_q |-> vectorAddr_q ==
      {$past(vectorSegmentSelect_q), {5'h00, branchTrapNum_q} << ($past(vectorSpacingField_q) + 2)})
      else $error("vector address wrong");
   a_node_prio: assert property (branchReq_q && !branchIsTrap_q |-> branchPrio_q > $past(cpuPrio))
      else $error("node prio not above cpu");
   a_flag_set: assert property ((swSetReq & ~nodeRequestFlag_q) != 0 |=>
      ($past(swSetReq) & ~nodeRequestFlag_q) == 0)
      else $error("request flag not set");
endmodule
bind ivt_trap_entry ivt_trap_entry_monitor mon (.core_clk, .arst_n, .swSetReq, .trapEvent, .trapFlagClr, .cpuPrio,
   .nodeRequestFlag_q, .trapFlagRegister_q, .vectorSegmentSelect_q, .vectorSpacingField_q, .branchReq_q,
   .branchIsTrap_q, .branchTrapNum_q, .branchPrio_q, .eventXferReq_q, .trapActive_q, .vectorAddr_q);

/* tb/ivt_cpu_model.sv */
`timescale 1ns/1ps
module ivt_cpu_model #(parameter DLY = 6) (
   input wire core_clk,
   input wire arst_n,
   input wire branchReq,
   output reg done_q
);
   integer cnt_q;
   // Each branch starts a service; a nested one restarts the count, so only the newest returns
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= branchReq ? DLY : (cnt_q > 0 ? cnt_q - 1 : 0);
         done_q <= (cnt_q == 1) && !branchReq;
      end
   end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   reg core_clk, arst_n, segWrEn, spcWrEn;
   reg [7:0] periphReq, swSetReq, swClrReq, nodeEnable, nodeToEvent, segWrData;
   reg [3:0] trapEvent, trapFlagClr, cpuPrio;
   reg [31:0] nodePrio;
   reg [1:0] spcWrData;
   wire [7:0] nodeRequestFlag_q, vectorSegmentSelect_q;
   wire [3:0] trapFlagRegister_q, branchPrio_q;
   wire [1:0] vectorSpacingField_q;
   wire [6:0] branchTrapNum_q;
   wire [2:0] eventXferNode_q;
   wire [19:0] vectorAddr_q;
   wire branchReq_q, branchIsTrap_q, eventXferReq_q, trapActive_q, done_q;
   integer n_mismatch = 0, comparisons = 0, cyc = 0;
   ivt_trap_entry uut (.core_clk, .arst_n, .periphReq, .swSetReq, .swClrReq, .nodeEnable, .nodePrio, .nodeToEvent,
      .trapEvent, .trapFlagClr, .segWrData, .segWrEn, .spcWrData, .spcWrEn, .serviceDone(done_q), .cpuPrio,
      .nodeRequestFlag_q, .trapFlagRegister_q, .vectorSegmentSelect_q, .vectorSpacingField_q, .branchReq_q,
      .branchIsTrap_q, .branchTrapNum_q, .branchPrio_q, .eventXferReq_q, .eventXferNode_q, .trapActive_q, .vectorAddr_q);
   ivt_cpu_model #(.DLY(6)) cpu (.core_clk, .arst_n, .branchReq(branchReq_q), .done_q);
   // Clock, and a ceiling well above the roughly fifty cycles the tests need
   initial begin
      core_clk = 0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         complete_run;
      end
   end
   task complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input [23:0] e, input [23:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One-cycle request pulses, launched on the falling edge
   task automatic pul(input [7:0] s, input [3:0] t);
      @(negedge core_clk);
      swSetReq = s;
      trapEvent = t;
      @(negedge core_clk);
      swSetReq = 0;
      trapEvent = 0;
   endtask
   // Bounded wait; callers make sure an older pulse has gone
   task automatic wt(input ev);
      integer i = 0;
      while ((ev ? eventXferReq_q : branchReq_q) !== 1'b1 && i < 40) begin
         @(posedge core_clk);
         #1;
         i++;
      end
   endtask
   task automatic wb(input [6:0] num);
      wt(0);
      chk("branchReq", 1, branchReq_q);
      chk("trapNum", num, branchTrapNum_q);
   endtask
   initial begin
      {arst_n, segWrEn, spcWrEn, periphReq, swSetReq, swClrReq, nodeToEvent, segWrData} = 0;
      {trapEvent, trapFlagClr, cpuPrio, spcWrData} = 0;
      nodeEnable = 8'hFF;
      nodePrio = 32'h0590_2713;
      repeat (2) @(negedge core_clk);
      arst_n = 1;
      chk("resetOut", 0, {vectorSegmentSelect_q, vectorSpacingField_q, trapFlagRegister_q, nodeRequestFlag_q});
      // Peripheral node under a programmed segment
      segWrData = 8'h12;
      segWrEn = 1;
      periphReq = 8'h01;
      @(negedge core_clk);
      {segWrEn, periphReq} = 0;
      wb(7'h27);
      chk("vecAddr", 20'h1_209C, vectorAddr_q);
      $display("node test done");
      // Two software requests; the lower one waits below the cpu level
      @(negedge core_clk);
      cpuPrio = 4'h4;
      pul(8'h28, 0);
      wb(7'h2C);
      repeat (10) @(negedge core_clk);
      chk("pending", 8'h08, nodeRequestFlag_q);
      cpuPrio = 0;
      wb(7'h2A);
      $display("priority test done");
      // Wider spacing, then an event transfer
      @(negedge core_clk);
      spcWrData = 2'h1;
      spcWrEn = 1;
      @(negedge core_clk);
      spcWrEn = 0;
      pul(8'h02, 0);
      wb(7'h28);
      chk("vecAddr", 20'h1_2140, vectorAddr_q);
      @(negedge core_clk);
      nodeToEvent = 8'h40;
      pul(8'h40, 0);
      wt(1);
      chk("xferReq", 1, eventXferReq_q);
      chk("xferNode", 3'h6, eventXferNode_q);
      $display("spacing test done");
      // Traps: lower one and a node wait, top one preempts
      pul(0, 4'h2);
      chk("trapAct", 1, {branchReq_q, trapActive_q, branchTrapNum_q} == 9'h184);
      pul(8'h04, 4'h4);
      pul(0, 4'h1);
      chk("trapNum", 7'h02, branchTrapNum_q);
      repeat (2) @(negedge core_clk);
      wb(7'h06);
      chk("trapFlags", 4'h7, trapFlagRegister_q);
      repeat (2) @(negedge core_clk);
      wb(7'h29);
      $display("trap test done");
      // A disabled node stays pending until software clears it; trap flags clear on request
      @(negedge core_clk);
      nodeEnable = 8'hFE;
      trapFlagClr = 4'hF;
      pul(8'h01, 0);
      repeat (2) @(negedge core_clk);
      chk("pending", 8'h01, nodeRequestFlag_q);
      chk("trapFlags", 0, trapFlagRegister_q);
      {swClrReq, trapFlagClr} = {8'h01, 4'h0};
      @(negedge core_clk);
      swClrReq = 0;
      chk("cleared", 0, {nodeRequestFlag_q, branchReq_q});
      $display("clear test done");
      complete_run;
   end
endmodule
